// ---- include/frm_pkg.sv ----
// Constants, types and register map of the flash access and mirror block
package frm_pkg;
  localparam int          ADDR_W        = 24;
  localparam int          OFF_W         = 16;
  localparam int          DATA_W        = 8;
  localparam int          WB_AW         = 4;
  localparam int          WB_DW         = 32;
  localparam logic [7:0]  BANK_FLASH    = 8'hFF;
  localparam logic [7:0]  BANK_ZERO     = 8'h00;
  localparam int          MIR_WIN_BIT   = 15;
  localparam int          MIR_EN_BIT    = 8;
  localparam int          MIR_TOP_BIT   = 15;
  localparam int          MIR_SEL_LANE  = 1;
  localparam logic [3:0]  REG_MIRROR    = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h4;
  localparam int          STAT_BUSY     = 0;
  localparam int          STAT_FMODE    = 1;
  localparam logic [2:0]  MODE_FLASH    = 3'h7;
  localparam logic [15:0] CMD_ADR1      = 16'hAAAA;
  localparam logic [15:0] CMD_ADR2      = 16'h5554;
  localparam logic [7:0]  D_UNLK1       = 8'hAA;
  localparam logic [7:0]  D_UNLK2       = 8'h55;
  localparam logic [7:0]  D_PROG        = 8'hA0;
  localparam logic [7:0]  D_ERASE_SETUP = 8'h80;
  localparam logic [7:0]  D_CHIP_ERASE  = 8'h10;
  localparam logic [7:0]  D_RESET       = 8'hF0;
  localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
  localparam logic [15:0] ERASE_LAST    = 16'hFFFF;
  localparam logic [15:0] OFF_ZERO      = 16'h0000;
  localparam logic [1:0]  READ_CYC      = 2'h2;
  localparam logic [1:0]  CNT_FIRST     = 2'h1;
  localparam logic [1:0]  CNT_IDLE      = 2'h0;

  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_UNLK1 = 8'h02,
    ST_UNLK2 = 8'h04,
    ST_PROG  = 8'h08,
    ST_ERS1  = 8'h10,
    ST_ERS2  = 8'h20,
    ST_ERS3  = 8'h40,
    ST_ERASE = 8'h80
  } frm_cmd_e;
endpackage

// ---- include/frm_arr_if.sv ----
// Port bundle between the access controller and the flash array
`timescale 1ns/1ps
`default_nettype none
interface frm_arr_if;
  import frm_pkg::*;
  logic              rdEn;
  logic [OFF_W-1:0]  rdAddr;
  logic [DATA_W-1:0] rdData;
  logic              wrEn;
  logic              wrErase;
  logic [OFF_W-1:0]  wrAddr;
  logic [DATA_W-1:0] wrData;

  modport ctrl (
    output rdEn, rdAddr, wrEn, wrErase, wrAddr, wrData,
    input  rdData
  );
  modport array (
    input  rdEn, rdAddr, wrEn, wrErase, wrAddr, wrData,
    output rdData
  );
endinterface
`default_nettype wire

// ---- rtl/frm_flash_array.sv ----
// Flash storage array: registered read, bitwise program, byte erase
`timescale 1ns/1ps
`default_nettype none
module frm_flash_array
  import frm_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Controller side
  frm_arr_if.array arr
);
  logic [DATA_W-1:0] mem [0:(1<<OFF_W)-1];
  logic [DATA_W-1:0] rdDataQ;

  // Programming can only clear bits; erase returns a byte to all ones
  always_ff @(posedge ref_clk) begin
    if (arr.wrEn) begin
      if (arr.wrErase) begin
        mem[arr.wrAddr] <= ERASED_BYTE;
      end else begin
        mem[arr.wrAddr] <= mem[arr.wrAddr] & arr.wrData;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (arr.rdEn) begin
      rdDataQ <= mem[arr.rdAddr];
    end
  end

  assign arr.rdData = rdDataQ;
endmodule
`default_nettype wire

// ---- rtl/frm_top.sv ----
// Flash program memory access, mode straps and bank-zero mirror
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Mirror enable bit written 1 turns mirror on, written 0 off.
// - Mirror on: bank-zero reads 008000-00FFFF return FF8000-FFFFFF.
// - Upper mirror register bits read zero; writing them does nothing.
// - Flash sits in top bank; reads and fetches served like ROM.
// - Every CPU flash read takes at least two cycles.
// - No command ever makes maker or device codes readable.
// - Mode pins 111 at reset halt CPU and hand array to pins.
// - Outside pin mode, CPU writes to top bank issue commands.
// - Pin mode uses eight data pins only, single byte transfers.
// - Pin mode supports every program and erase operation.
module frm_top
  import frm_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Wishbone slave
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [WB_AW-1:0]  wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [WB_DW-1:0]  wbDatI,
  output logic      [WB_DW-1:0]  wbDatO,
  output logic                   wbAck,
  // CPU memory port
  input  wire logic              cpuReq,
  input  wire logic              cpuWe,
  input  wire logic [ADDR_W-1:0] cpuAddr,
  input  wire logic [DATA_W-1:0] cpuWdata,
  output logic      [DATA_W-1:0] cpuRdata,
  output logic                   cpuAck,
  output logic                   cpuHalt,
  // Mode straps
  input  wire logic [2:0]        modePins,
  // Programmer pins
  input  wire logic              extCeN,
  input  wire logic              extOeN,
  input  wire logic              extWeN,
  input  wire logic [OFF_W-1:0]  extAddr,
  input  wire logic [DATA_W-1:0] extDataI,
  output logic      [DATA_W-1:0] extDataO,
  output logic                   extDataOe,
  output logic                   extReadyBusy
);
  frm_arr_if arrIf ();

  frm_flash_array u_array (
    .ref_clk (ref_clk),
    .arr     (arrIf.array)
  );

  function automatic logic isFlashBank(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:OFF_W] == BANK_FLASH;
  endfunction

  function automatic logic inMirrorWin(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:OFF_W] == BANK_ZERO) && a[MIR_WIN_BIT];
  endfunction

  // Synchronisers
  logic [2:0]        mdS1, mdS2;
  logic              ceS1, ceS2, oeS1, oeS2, weS1, weS2, weDlyQ;
  logic [OFF_W-1:0]  adS1, adS2;
  logic [DATA_W-1:0] dtS1, dtS2;

  always_ff @(posedge ref_clk) begin
    mdS1 <= modePins;
    mdS2 <= mdS1;
    ceS1 <= extCeN;
    ceS2 <= ceS1;
    oeS1 <= extOeN;
    oeS2 <= oeS1;
    weS1 <= extWeN;
    weS2 <= weS1;
    adS1 <= extAddr;
    adS2 <= adS1;
    dtS1 <= extDataI;
    dtS2 <= dtS1;
  end

  // Strap capture in the first cycle after reset release
  logic strapDoneQ, flashModeQ;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      strapDoneQ <= 1'b0;
      flashModeQ <= 1'b0;
    end else if (!strapDoneQ) begin
      strapDoneQ <= 1'b1;
      flashModeQ <= (mdS2 == MODE_FLASH);
    end
  end

  assign cpuHalt = !strapDoneQ || flashModeQ;

  // Programmer pin decoding
  logic extRd, extWrFall, extRdQ;
  logic [DATA_W-1:0] extDataQ;
  logic              extOeQ;

  assign extRd     = flashModeQ && !ceS2 && !oeS2;
  assign extWrFall = flashModeQ && weDlyQ && !weS2 && !ceS2;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      weDlyQ   <= 1'b1;
      extRdQ   <= 1'b0;
      extOeQ   <= 1'b0;
      extDataQ <= '0;
    end else begin
      weDlyQ <= weS2;
      extRdQ <= extRd;
      extOeQ <= extRdQ && extRd;
      if (extRdQ) begin
        extDataQ <= arrIf.rdData;
      end
    end
  end

  assign extDataO  = extDataQ;
  assign extDataOe = extOeQ;

  // Wishbone register file
  logic              mirEnQ, wbAckQ;
  logic [WB_DW-1:0]  wbDatQ;
  logic              wbTake, wbWrMir;
  logic [WB_DW-1:0]  rdMux;
  frm_cmd_e          stQ, stD;

  assign wbTake  = wbCyc && wbStb && !wbAckQ;
  assign wbWrMir = wbTake && wbWe && (wbAdr == REG_MIRROR)
                   && wbSel[MIR_SEL_LANE];

  always_comb begin
    rdMux = '0;
    case (wbAdr)
      REG_MIRROR: rdMux[MIR_EN_BIT] = mirEnQ;
      REG_STATUS: begin
        rdMux[STAT_BUSY]  = (stQ == ST_ERASE);
        rdMux[STAT_FMODE] = flashModeQ;
      end
      default: rdMux = '0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wbAckQ <= 1'b0;
      wbDatQ <= '0;
    end else begin
      wbAckQ <= wbTake;
      if (wbTake && !wbWe) begin
        wbDatQ <= rdMux;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mirEnQ <= 1'b0;
    end else if (wbWrMir) begin
      mirEnQ <= wbDatI[MIR_EN_BIT];
    end
  end

  assign wbAck  = wbAckQ;
  assign wbDatO = wbDatQ;

  // CPU access sequencing
  logic              cpuTake, cpuActQ, cpuDoneQ, cpuHitQ;
  logic [1:0]        cpuCntQ;
  logic [DATA_W-1:0] cpuRdQ;
  logic              cpuRdHit;
  logic [OFF_W-1:0]  cpuOff;

  assign cpuTake  = cpuReq && !cpuActQ && !cpuDoneQ && !cpuHalt;
  assign cpuRdHit = isFlashBank(cpuAddr)
                    || (mirEnQ && inMirrorWin(cpuAddr));
  // Mirror window offset already has its top bit set
  assign cpuOff   = cpuRdHit ? cpuAddr[OFF_W-1:0] : OFF_ZERO;
  assign cpuAck   = cpuActQ && (cpuCntQ == READ_CYC);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cpuActQ  <= 1'b0;
      cpuDoneQ <= 1'b0;
      cpuHitQ  <= 1'b0;
      cpuCntQ  <= CNT_IDLE;
      cpuRdQ   <= '0;
    end else begin
      cpuDoneQ <= cpuAck;
      if (cpuTake) begin
        cpuActQ <= 1'b1;
        cpuHitQ <= !cpuWe && cpuRdHit;
        // Writes answer next cycle, reads after two
        cpuCntQ <= cpuWe ? READ_CYC : CNT_FIRST;
      end else if (cpuAck) begin
        cpuActQ <= 1'b0;
        cpuCntQ <= CNT_IDLE;
      end else if (cpuActQ) begin
        cpuCntQ <= cpuCntQ + CNT_FIRST;
        cpuRdQ  <= cpuHitQ ? arrIf.rdData : '0;
      end
    end
  end

  assign cpuRdata = cpuRdQ;

  // Command sequencer shared by CPU and programmer pins
  logic              cmdWr;
  logic [OFF_W-1:0]  cmdAddr;
  logic [DATA_W-1:0] cmdData;
  logic [OFF_W-1:0]  ersAddrQ;

  always_comb begin
    if (flashModeQ) begin
      cmdWr   = extWrFall;
      cmdAddr = adS2;
      cmdData = dtS2;
    end else begin
      cmdWr   = cpuTake && cpuWe && isFlashBank(cpuAddr);
      cmdAddr = cpuAddr[OFF_W-1:0];
      cmdData = cpuWdata;
    end
  end

  // Outside a running erase, any unknown code, an identify request among them, falls back to idle
  always_comb begin
    stD = stQ;
    case (stQ)
      ST_IDLE: begin
        if (cmdWr && cmdAddr == CMD_ADR1 && cmdData == D_UNLK1) begin
          stD = ST_UNLK1;
        end
      end
      ST_UNLK1: begin
        if (cmdWr) begin
          stD = (cmdAddr == CMD_ADR2 && cmdData == D_UNLK2)
                ? ST_UNLK2 : ST_IDLE;
        end
      end
      ST_UNLK2: begin
        if (cmdWr) begin
          if (cmdAddr == CMD_ADR1 && cmdData == D_PROG) begin
            stD = ST_PROG;
          end else if (cmdAddr == CMD_ADR1 && cmdData == D_ERASE_SETUP) begin
            stD = ST_ERS1;
          end else begin
            stD = ST_IDLE;
          end
        end
      end
      ST_PROG: begin
        if (cmdWr) begin
          stD = ST_IDLE;
        end
      end
      ST_ERS1: begin
        if (cmdWr) begin
          stD = (cmdAddr == CMD_ADR1 && cmdData == D_UNLK1)
                ? ST_ERS2 : ST_IDLE;
        end
      end
      ST_ERS2: begin
        if (cmdWr) begin
          stD = (cmdAddr == CMD_ADR2 && cmdData == D_UNLK2)
                ? ST_ERS3 : ST_IDLE;
        end
      end
      ST_ERS3: begin
        if (cmdWr) begin
          stD = (cmdAddr == CMD_ADR1 && cmdData == D_CHIP_ERASE)
                ? ST_ERASE : ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (ersAddrQ == ERASE_LAST) begin
          stD = ST_IDLE;
        end
      end
      default: stD = ST_IDLE;
    endcase
    // Reset code aborts a pending sequence but never a running erase
    if (cmdWr && cmdData == D_RESET && stQ != ST_ERASE) begin
      stD = ST_IDLE;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stQ <= ST_IDLE;
    end else begin
      stQ <= stD;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ersAddrQ <= OFF_ZERO;
    end else if (stQ == ST_ERASE) begin
      ersAddrQ <= ersAddrQ + 16'h0001;
    end else begin
      ersAddrQ <= OFF_ZERO;
    end
  end

  // Array port
  assign arrIf.rdEn    = flashModeQ ? extRd : (cpuTake && !cpuWe);
  assign arrIf.rdAddr  = flashModeQ ? adS2 : cpuOff;
  assign arrIf.wrErase = (stQ == ST_ERASE);
  assign arrIf.wrEn    = (stQ == ST_ERASE)
                         || (cmdWr && stQ == ST_PROG && cmdData != D_RESET);
  assign arrIf.wrAddr  = (stQ == ST_ERASE) ? ersAddrQ : cmdAddr;
  assign arrIf.wrData  = cmdData;

  assign extReadyBusy = (stQ != ST_ERASE);

  // Checks
  a_read_latency: assert property (@(posedge ref_clk) disable iff (rst)
    cpuTake && !cpuWe |=> !cpuAck ##1 cpuAck)
    else $error("flash read not answered in two cycles");

  a_mirror_map: assert property (@(posedge ref_clk) disable iff (rst)
    cpuTake && !cpuWe && mirEnQ && inMirrorWin(cpuAddr)
    |-> arrIf.rdEn && arrIf.rdAddr == cpuAddr[OFF_W-1:0]
        ##1 cpuHitQ)
    else $error("mirror window read not redirected");

  a_mirror_off: assert property (@(posedge ref_clk) disable iff (rst)
    cpuTake && !cpuWe && !mirEnQ && inMirrorWin(cpuAddr)
    |=> ##1 cpuAck && cpuRdata == '0)
    else $error("mirror window read while mirror off");

  a_mirror_write: assert property (@(posedge ref_clk) disable iff (rst)
    wbWrMir |=> wbAck && mirEnQ == $past(wbDatI[MIR_EN_BIT]))
    else $error("mirror enable not updated by write");

  a_upper_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    wbTake && !wbWe && wbAdr == REG_MIRROR
    |=> wbAck && wbDatO[MIR_TOP_BIT:MIR_EN_BIT+1] == '0)
    else $error("mirror register upper bits not quiet");

  a_strap_halt: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(strapDoneQ) && $past(mdS2) == MODE_FLASH
    |-> flashModeQ && cpuHalt)
    else $error("flash mode strap did not halt cpu");

  a_halt_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    flashModeQ |-> !cpuAck && !cpuTake)
    else $error("cpu access served in flash mode");

  a_ext_read: assert property (@(posedge ref_clk) disable iff (rst)
    extRd ##1 extRd |=> extDataOe)
    else $error("programmer read not driven");

  a_prog_write: assert property (@(posedge ref_clk) disable iff (rst)
    cmdWr && stQ == ST_PROG && cmdData != D_RESET
    |-> arrIf.wrEn && !arrIf.wrErase && arrIf.wrAddr == cmdAddr)
    else $error("program command did not write array");

  a_rom_guard: assert property (@(posedge ref_clk) disable iff (rst)
    cpuTake && cpuWe && !isFlashBank(cpuAddr) |-> !arrIf.wrEn || stQ == ST_ERASE)
    else $error("write outside top bank reached array");

  a_no_ident: assert property (@(posedge ref_clk) disable iff (rst)
    cmdWr && stQ == ST_UNLK2 && cmdData != D_PROG
    && cmdData != D_ERASE_SETUP |=> stQ == ST_IDLE)
    else $error("unknown command left sequencer armed");

  a_erase_walk: assert property (@(posedge ref_clk) disable iff (rst)
    stQ == ST_ERASE |-> arrIf.wrEn && arrIf.wrErase && !extReadyBusy)
    else $error("chip erase not erasing");
endmodule
`default_nettype wire

// ---- rtl/placeholder_none.sv ----
// Intentionally empty
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- verif/frm_cpu_model.sv ----
// CPU-side bus master facing the flash access block
`timescale 1ns/1ps
`default_nettype none
module frm_cpu_model
  import frm_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Memory port
  output logic                   cpuReq,
  output logic                   cpuWe,
  output logic      [ADDR_W-1:0] cpuAddr,
  output logic      [DATA_W-1:0] cpuWdata,
  input  wire logic [DATA_W-1:0] cpuRdata,
  input  wire logic              cpuAck
);
  initial begin
    {cpuReq, cpuWe, cpuAddr, cpuWdata} = '0;
  end

  // Holds the request until ack; n is edges to ack, -1 on timeout
  task automatic acc(input logic we, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] wd,
                     output logic [DATA_W-1:0] rd, output int n);
    @(posedge ref_clk);
    {cpuReq, cpuWe, cpuAddr} <= {1'b1, we, a};
    cpuWdata <= we ? wd : ~cpuWdata;
    @(posedge ref_clk);
    for (n = 1; n < 16 && cpuAck !== 1'b1; n++) @(posedge ref_clk);
    rd = cpuRdata;
    cpuReq <= 1'b0;
    if (cpuAck !== 1'b1) n = -1;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench: registers, CPU reads, mirror, programmer pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import frm_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [WB_AW-1:0]  wbAdr = '0;
  logic [3:0]        wbSel = '0;
  logic [WB_DW-1:0]  wbDatI = '0, wbDatO;
  logic              wbAck, cpuReq, cpuWe, cpuAck, cpuHalt;
  logic [ADDR_W-1:0] cpuAddr;
  logic [DATA_W-1:0] cpuWdata, cpuRdata, extDataO, extDataI = '0;
  logic [2:0]        modePins = '0;
  logic              extCeN = 1'b1, extOeN = 1'b1, extWeN = 1'b1;
  logic              extDataOe, extReadyBusy;
  logic [OFF_W-1:0]  extAddr = '0;
  logic [7:0]        mem [int];
  logic [31:0]       rnd = 32'hBA02;
  int                errorCnt = 0, testsRun = 0;

  always #10 ref_clk = ~ref_clk;

  frm_top uut (.ref_clk(ref_clk), .rst(rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAck(wbAck), .cpuReq(cpuReq), .cpuWe(cpuWe),
    .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .cpuAck(cpuAck), .cpuHalt(cpuHalt), .modePins(modePins),
    .extCeN(extCeN), .extOeN(extOeN), .extWeN(extWeN), .extAddr(extAddr),
    .extDataI(extDataI), .extDataO(extDataO), .extDataOe(extDataOe),
    .extReadyBusy(extReadyBusy));

  frm_cpu_model cpuM (.ref_clk(ref_clk), .cpuReq(cpuReq), .cpuWe(cpuWe),
    .cpuAddr(cpuAddr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .cpuAck(cpuAck));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Reference read: top bank, or mirrored window of bank zero
  function automatic logic [7:0] expRd(input logic [23:0] a,
                                       input logic mirOn);
    if (a[23:16] == BANK_FLASH || (mirOn && a[23:16] == BANK_ZERO && a[15]))
      return mem.exists(int'(a[15:0])) ? mem[int'(a[15:0])] : ERASED_BYTE;
    return 8'h00;
  endfunction

  // Reference program: a reset code aborts the sequence instead
  function automatic void prgRef(input logic [15:0] o, input logic [7:0] d);
    if (d != D_RESET) mem[int'(o)] = expRd({BANK_FLASH, o}, 1'b0) & d;
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    testsRun++;
    if (g !== e) begin
      errorCnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic hang(input string nm);
    errorCnt++;
    $display("wrong value %s expected answer seen timeout", nm);
    tally_and_finish();
  endtask

  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI, wbSel} <= {2'b11, we, a, d, 4'hF};
    @(posedge ref_clk);
    for (n = 0; n < 16 && wbAck !== 1'b1; n++) @(posedge ref_clk);
    q = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
    if (wbAck !== 1'b1) hang("wbAck");
  endtask

  task automatic cpu(input logic we, input logic [23:0] a,
                     input logic [7:0] wd, output logic [7:0] rd);
    int n;
    cpuM.acc(we, a, wd, rd, n);
    if (n < 0) hang("cpuAck");
    else if (!we) chk("read latency", 32'h1, {31'h0, n >= 3});
  endtask

  task automatic cmd(input logic [7:0] d3);
    logic [7:0] r;
    cpu(1'b1, {BANK_FLASH, CMD_ADR1}, D_UNLK1, r);
    cpu(1'b1, {BANK_FLASH, CMD_ADR2}, D_UNLK2, r);
    cpu(1'b1, {BANK_FLASH, CMD_ADR1}, d3, r);
  endtask

  // Byte lanes only, one byte per write strobe
  task automatic pinWr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {extCeN, extWeN, extAddr, extDataI} <= {2'b00, a, d};
    repeat (4) @(posedge ref_clk);
    extWeN <= 1'b1;
    repeat (4) @(posedge ref_clk);
    {extCeN, extDataI} <= {1'b1, ~d};
  endtask

  task automatic pinRd(input logic [15:0] a);
    int n;
    @(posedge ref_clk);
    {extCeN, extOeN, extAddr} <= {2'b00, a};
    for (n = 0; n < 16 && extDataOe !== 1'b1; n++) @(posedge ref_clk);
    if (extDataOe !== 1'b1) hang("extDataOe");
    chk("extDataO", {24'h0, expRd({BANK_FLASH, a}, 1'b0)}, {24'h0, extDataO});
    {extCeN, extOeN} <= 2'b11;
    repeat (6) @(posedge ref_clk);
    chk("extDataOe idle", 32'h0, {31'h0, extDataOe});
  endtask

  initial begin
    logic [31:0] q;
    logic [7:0]  r;
    logic [15:0] offs [$];
    logic        mirOn;
    int          n;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wb(1'b0, REG_MIRROR, 32'h0, q);
    chk("mirror at reset", 32'h0, {31'h0, q[MIR_EN_BIT]});
    wb(1'b0, 4'h8, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    repeat (3) @(posedge ref_clk);
    chk("cpuHalt", 32'h0, {31'h0, cpuHalt});
    cmd(D_ERASE_SETUP);
    cmd(D_CHIP_ERASE);
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("erase busy", 32'h1, {31'h0, q[STAT_BUSY]});
    chk("extReadyBusy", 32'h0, {31'h0, extReadyBusy});
    // Software polls from RAM until done
    for (n = 0; n < 40000 && q[STAT_BUSY] !== 1'b0; n++)
      wb(1'b0, REG_STATUS, 32'h0, q);
    if (q[STAT_BUSY] !== 1'b0) hang("erase end");
    cmd(D_RESET);
    cmd(8'h90);
    // Stray write with no program armed must not reach the array
    cpu(1'b1, {BANK_FLASH, OFF_ZERO}, 8'h00, r);
    cpu(1'b0, {BANK_FLASH, OFF_ZERO}, 8'h00, r);
    chk("no identify", 32'hFF, {24'h0, r});
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      offs.push_back({1'b1, rnd[14:0]});
      cmd(D_PROG);
      cpu(1'b1, {BANK_FLASH, offs[i]}, rnd[23:16], r);
      prgRef(offs[i], rnd[23:16]);
    end
    for (int m = 0; m < 2; m++) begin
      mirOn = m[0];
      // Window idle while switching
      wb(1'b1, REG_MIRROR, {16'h0, 7'h7F, mirOn, 8'h00}, q);
      wb(1'b0, REG_MIRROR, 32'h0, q);
      chk("mirror bit", {31'h0, mirOn}, {31'h0, q[MIR_EN_BIT]});
      foreach (offs[k]) begin
        cpu(1'b0, {BANK_FLASH, offs[k]}, 8'h00, r);
        chk("top bank", {24'h0, expRd({BANK_FLASH, offs[k]}, mirOn)},
            {24'h0, r});
        cpu(1'b0, {BANK_ZERO, offs[k]}, 8'h00, r);
        chk("mirror hi", {24'h0, expRd({BANK_ZERO, offs[k]}, mirOn)},
            {24'h0, r});
        cpu(1'b0, {BANK_ZERO, 1'b0, offs[k][14:0]}, 8'h00, r);
        chk("mirror lo", 32'h0, {24'h0, r});
      end
    end
    modePins <= MODE_FLASH;
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("cpuHalt", 32'h1, {31'h0, cpuHalt});
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk("flash mode", 32'h1, {31'h0, q[STAT_FMODE]});
    wb(1'b0, REG_MIRROR, 32'h0, q);
    chk("mirror at reset", 32'h0, {31'h0, q[MIR_EN_BIT]});
    pinRd(offs[0]);
    rnd = lfsr(rnd);
    pinWr(CMD_ADR1, D_UNLK1);
    pinWr(CMD_ADR2, D_UNLK2);
    pinWr(CMD_ADR1, D_PROG);
    pinWr(offs[1], rnd[7:0]);
    prgRef(offs[1], rnd[7:0]);
    pinRd(offs[1]);
    chk("extReadyBusy", 32'h1, {31'h0, extReadyBusy});
    tally_and_finish();
  end
endmodule
`default_nettype wire
